/* File: temp_sensor_register_bank.sv */
// Register bank of a temperature sensor, reached through an address pointer
//
// What this block does
// - All registers are eight bits wide
// - Result, status, ID read-only; reset write-only
// - Pointer loads zero at power-up
// - Pointer is eight bits of register address
// - Decode 0x00 to 0x0B and 0x2F
// - Result is two's complement, top bit sign
// - Reading high byte steps pointer to low byte
// - High byte holds sign and magnitude bits
// - Resolution bit picks extended bits or flags
// - Thirteen-bit: bit 0 set below low limit
// - Thirteen-bit: bit 1 set above high limit
// - Thirteen-bit: bit 2 set above critical limit
// - Limit flags clear on read or return
// - Result read returns done flag inactive
// - Mode write in one-shot/1 SPS does too
// - New result drives done flag low, idle high
// - Status flags at bits 4-6, 3-0 zero
// - Mode bits: continuous, one-shot, once per second
`timescale 1ns/10ps
`include "temp_bank_consts.svh"
module temp_sensor_register_bank
    import temp_bank_pkg::*;
#(
    parameter logic [7:0] IDENT_VALUE = 8'h5A // Arbitrary identification value
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_wr_valid,
    input wire logic i_wr_first,
    input wire logic [7:0] i_wr_data,
    input wire logic i_rd_req,
    input wire logic i_result_valid,
    input wire logic [15:0] i_result,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    output logic [7:0] o_config,
    output logic [15:0] o_high_limit,
    output logic [15:0] o_low_limit,
    output logic [15:0] o_critical_limit,
    output logic [7:0] o_hysteresis,
    output logic [7:0] o_status,
    output logic o_soft_reset
);

    // Power-on contents of every register
    localparam bank_state_t RESET_STATE = '{
        pointer: `RST_POINTER,
        temp_high: `RST_TEMP_HIGH,
        temp_low: `RST_TEMP_LOW,
        conv_done_n: `RST_CONV_DONE_N,
        crit_flag: `RST_FLAG,
        high_flag: `RST_FLAG,
        low_flag: `RST_FLAG,
        config_reg: `RST_CONFIG,
        high_upper: `RST_HIGH_UPPER,
        high_lower: `RST_HIGH_LOWER,
        low_upper: `RST_LOW_UPPER,
        low_lower: `RST_LOW_LOWER,
        crit_upper: `RST_CRIT_UPPER,
        crit_lower: `RST_CRIT_LOWER,
        hyst: `RST_HYST,
        rd_data: `READ_ZERO,
        rd_valid: 1'b0,
        soft_reset: 1'b0
    };

    bank_state_t state_r;
    bank_state_t state_nxt;

    limit_if lim ();

    logic hi_res;
    logic [15:0] result_cmp;
    logic [1:0] new_mode;
    logic host_write;
    logic host_read;
    logic pointer_write;
    logic data_write;
    logic status_read;
    logic result_read;
    logic mode_write_clear;
    logic [7:0] status_view;
    logic [7:0] read_mux;
    logic [2:0] flag_trip;
    logic [2:0] flag_clear;
    logic [2:0] flag_now;
    logic [2:0] flag_next;
    logic [7:0] stored_low;
    logic cfg_write;
    logic high_upper_write;
    logic high_lower_write;
    logic low_upper_write;
    logic low_lower_write;
    logic crit_upper_write;
    logic crit_lower_write;
    logic hyst_write;
    logic soft_write;

    // Result as it will be stored; flag slots zeroed for comparison
    assign hi_res = state_r.config_reg[`CFG_RES_BIT];
    always_comb begin
        result_cmp = i_result;
        if (!hi_res) begin
            result_cmp[`RES_FLAG_HI:0] = '0;
        end
    end

    // Feed the limit evaluator with the stored setpoints
    assign lim.temp = result_cmp;
    assign lim.limit[`IDX_LOW] = {state_r.low_upper, state_r.low_lower};
    assign lim.limit[`IDX_HIGH] = {state_r.high_upper, state_r.high_lower};
    assign lim.limit[`IDX_CRIT] = {state_r.crit_upper, state_r.crit_lower};
    assign lim.hyst = state_r.hyst;

    limit_eval u_limit_eval (
        .lim(lim.eval)
    );

    assign flag_trip = lim.trip;
    assign flag_clear = lim.clear;

    // Low result byte: extended bits, or flag slots in 13-bit mode
    always_comb begin
        stored_low = i_result[7:0];
        if (!hi_res) begin
            stored_low[`RES_FLAG_HI:0] = {flag_trip[`IDX_CRIT], flag_trip[`IDX_HIGH],
                flag_trip[`IDX_LOW]};
        end
    end

    // Host access qualifiers; a write in the same cycle as a read wins
    assign host_write = i_wr_valid;
    assign host_read = i_rd_req && !i_wr_valid;
    assign pointer_write = host_write && i_wr_first;
    assign data_write = host_write && !i_wr_first;
    assign status_read = host_read && (state_r.pointer == `ADDR_STATUS);
    assign result_read = host_read &&
        ((state_r.pointer == `ADDR_TEMP_HIGH) || (state_r.pointer == `ADDR_TEMP_LOW));

    // One write strobe per writable location; read-only ones get none
    assign cfg_write = data_write && (state_r.pointer == `ADDR_CONFIG);
    assign high_upper_write = data_write && (state_r.pointer == `ADDR_HIGH_UPPER);
    assign high_lower_write = data_write && (state_r.pointer == `ADDR_HIGH_LOWER);
    assign low_upper_write = data_write && (state_r.pointer == `ADDR_LOW_UPPER);
    assign low_lower_write = data_write && (state_r.pointer == `ADDR_LOW_LOWER);
    assign crit_upper_write = data_write && (state_r.pointer == `ADDR_CRIT_UPPER);
    assign crit_lower_write = data_write && (state_r.pointer == `ADDR_CRIT_LOWER);
    assign hyst_write = data_write && (state_r.pointer == `ADDR_HYST);
    assign soft_write = data_write && (state_r.pointer == `ADDR_SOFT_RESET);

    // Sticky limit flags, one per channel; a tripping result beats any clear
    assign flag_now = {state_r.crit_flag, state_r.high_flag, state_r.low_flag};
    for (genvar i = 0; i < 3; i++) begin : g_flag
        assign flag_next[i] = (i_result_valid && flag_trip[i]) ? 1'b1 :
            (i_result_valid && flag_clear[i]) ? 1'b0 :
            (soft_write || status_read) ? `RST_FLAG : flag_now[i];
    end

    // Mode field of a configuration write
    assign new_mode = i_wr_data[`CFG_MODE_HI:`CFG_MODE_LO];
    assign mode_write_clear = data_write && (state_r.pointer == `ADDR_CONFIG) &&
        ((new_mode == `MODE_ONE_SHOT) || (new_mode == `MODE_ONE_SPS));

    // Status byte as the host sees it
    assign status_view = {state_r.conv_done_n, state_r.crit_flag, state_r.high_flag,
        state_r.low_flag, `STATUS_UNUSED};

    // Read data selected by the pointer; unmapped and write-only read zero
    always_comb begin
        unique case (state_r.pointer)
            `ADDR_TEMP_HIGH: read_mux = state_r.temp_high;
            `ADDR_TEMP_LOW: read_mux = state_r.temp_low;
            `ADDR_STATUS: read_mux = status_view;
            `ADDR_CONFIG: read_mux = state_r.config_reg;
            `ADDR_HIGH_UPPER: read_mux = state_r.high_upper;
            `ADDR_HIGH_LOWER: read_mux = state_r.high_lower;
            `ADDR_LOW_UPPER: read_mux = state_r.low_upper;
            `ADDR_LOW_LOWER: read_mux = state_r.low_lower;
            `ADDR_CRIT_UPPER: read_mux = state_r.crit_upper;
            `ADDR_CRIT_LOWER: read_mux = state_r.crit_lower;
            `ADDR_HYST: read_mux = state_r.hyst;
            `ADDR_IDENT: read_mux = IDENT_VALUE;
            `ADDR_SOFT_RESET: read_mux = `READ_ZERO;
            default: read_mux = `READ_ZERO;
        endcase
    end

    // Next state: host accesses first, hardware events last so they win
    always_comb begin
        state_nxt = state_r;
        state_nxt.rd_valid = 1'b0;
        state_nxt.soft_reset = 1'b0;

        // Pointer load, full eight bits of address
        if (pointer_write) begin
            state_nxt.pointer = i_wr_data;
        end

        // Data writes to writable locations only
        if (cfg_write) begin
            state_nxt.config_reg = i_wr_data;
        end
        if (high_upper_write) begin
            state_nxt.high_upper = i_wr_data;
        end
        if (high_lower_write) begin
            state_nxt.high_lower = i_wr_data;
        end
        if (low_upper_write) begin
            state_nxt.low_upper = i_wr_data;
        end
        if (low_lower_write) begin
            state_nxt.low_lower = i_wr_data;
        end
        if (crit_upper_write) begin
            state_nxt.crit_upper = i_wr_data;
        end
        if (crit_lower_write) begin
            state_nxt.crit_lower = i_wr_data;
        end
        if (hyst_write) begin
            state_nxt.hyst = i_wr_data;
        end

        // Software reset: whole bank back to power-on values, one-cycle pulse out
        if (soft_write) begin
            state_nxt = RESET_STATE;
            state_nxt.soft_reset = 1'b1;
        end

        // Done flag back to idle after a one-shot or 1 SPS mode write
        if (mode_write_clear) begin
            state_nxt.conv_done_n = 1'b1;
        end

        // Host read returns one byte the next cycle
        if (host_read) begin
            state_nxt.rd_valid = 1'b1;
            state_nxt.rd_data = read_mux;
            if (state_r.pointer == `ADDR_TEMP_HIGH) begin
                state_nxt.pointer = `ADDR_TEMP_LOW;
            end
        end

        // Reading the result returns the done flag to idle
        if (result_read) begin
            state_nxt.conv_done_n = 1'b1;
        end

        // New conversion result; its effects override host clears
        if (i_result_valid) begin
            state_nxt.temp_high = i_result[15:8];
            state_nxt.temp_low = stored_low;
            state_nxt.conv_done_n = 1'b0;
        end

        // Limit flags from the per-channel logic, after any soft reset
        state_nxt.low_flag = flag_next[`IDX_LOW];
        state_nxt.high_flag = flag_next[`IDX_HIGH];
        state_nxt.crit_flag = flag_next[`IDX_CRIT];
    end

    // State register; pointer and all others load their power-on values
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_r <= RESET_STATE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs taken straight from the state register
    assign o_rd_data = state_r.rd_data;
    assign o_rd_valid = state_r.rd_valid;
    assign o_config = state_r.config_reg;
    assign o_high_limit = {state_r.high_upper, state_r.high_lower};
    assign o_low_limit = {state_r.low_upper, state_r.low_lower};
    assign o_critical_limit = {state_r.crit_upper, state_r.crit_lower};
    assign o_hysteresis = state_r.hyst;
    assign o_status = {state_r.conv_done_n, state_r.crit_flag, state_r.high_flag,
        state_r.low_flag, `STATUS_UNUSED};
    assign o_soft_reset = state_r.soft_reset;

endmodule

/* File: temp_bank_consts.svh */
// Named addresses, reset values, field positions and codes of the register bank
`ifndef TEMP_BANK_CONSTS_SVH
`define TEMP_BANK_CONSTS_SVH

// Register addresses as seen through the pointer
`define ADDR_TEMP_HIGH 8'h00
`define ADDR_TEMP_LOW 8'h01
`define ADDR_STATUS 8'h02
`define ADDR_CONFIG 8'h03
`define ADDR_HIGH_UPPER 8'h04
`define ADDR_HIGH_LOWER 8'h05
`define ADDR_LOW_UPPER 8'h06
`define ADDR_LOW_LOWER 8'h07
`define ADDR_CRIT_UPPER 8'h08
`define ADDR_CRIT_LOWER 8'h09
`define ADDR_HYST 8'h0A
`define ADDR_IDENT 8'h0B
`define ADDR_SOFT_RESET 8'h2F

// Power-on values
`define RST_POINTER 8'h00
`define RST_TEMP_HIGH 8'h00
`define RST_TEMP_LOW 8'h00
`define RST_CONFIG 8'h00
`define RST_HIGH_UPPER 8'h20
`define RST_HIGH_LOWER 8'h00
`define RST_LOW_UPPER 8'h05
`define RST_LOW_LOWER 8'h00
`define RST_CRIT_UPPER 8'h49
`define RST_CRIT_LOWER 8'h80
`define RST_HYST 8'h05
`define RST_CONV_DONE_N 1'h1
`define RST_FLAG 1'h0
`define READ_ZERO 8'h00

// Configuration fields
`define CFG_RES_BIT 7
`define CFG_MODE_HI 6
`define CFG_MODE_LO 5
`define MODE_CONTINUOUS 2'h0
`define MODE_ONE_SHOT 2'h1
`define MODE_ONE_SPS 2'h2

// Status and result fields
`define STATUS_UNUSED 4'h0
`define RES_FLAG_HI 2
`define RES_TEMP_LO 3

// Limit channel indices and hysteresis scaling (one degree is 128 result LSBs)
`define IDX_LOW 0
`define IDX_HIGH 1
`define IDX_CRIT 2
`define HYST_PAD_HI 3'h0
`define HYST_PAD_LO 7'h00

`endif

/* File: temp_bank_pkg.sv */
// Types shared by the register bank modules
package temp_bank_pkg;

    // Whole state of the register bank
    typedef struct packed {
        logic [7:0] pointer;
        logic [7:0] temp_high;
        logic [7:0] temp_low;
        logic conv_done_n;
        logic crit_flag;
        logic high_flag;
        logic low_flag;
        logic [7:0] config_reg;
        logic [7:0] high_upper;
        logic [7:0] high_lower;
        logic [7:0] low_upper;
        logic [7:0] low_lower;
        logic [7:0] crit_upper;
        logic [7:0] crit_lower;
        logic [7:0] hyst;
        logic [7:0] rd_data;
        logic rd_valid;
        logic soft_reset;
    } bank_state_t;

endpackage

/* File: limit_if.sv */
// Carrier between the bank and its limit evaluator
`timescale 1ns/10ps
interface limit_if;
    logic [15:0] temp;
    logic [2:0][15:0] limit;
    logic [7:0] hyst;
    logic [2:0] trip;
    logic [2:0] clear;

    modport bank (output temp, output limit, output hyst, input trip, input clear);
    modport eval (input temp, input limit, input hyst, output trip, output clear);
endinterface

/* File: limit_eval.sv */
// Compares a result against the three limits, with hysteresis for release
`timescale 1ns/10ps
`include "temp_bank_consts.svh"
module limit_eval (
    limit_if.eval lim
);
    logic signed [17:0] temp_ext;
    logic signed [17:0] hyst_ext;

    // Hysteresis in degrees scaled to result LSBs
    assign temp_ext = {{2{lim.temp[15]}}, lim.temp};
    assign hyst_ext = {`HYST_PAD_HI, lim.hyst, `HYST_PAD_LO};

    // One comparator pair per limit
    for (genvar i = 0; i < 3; i++) begin : g_limit
        logic signed [17:0] lim_ext;
        assign lim_ext = {{2{lim.limit[i][15]}}, lim.limit[i]};
        if (i == `IDX_LOW) begin : g_under
            assign lim.trip[i] = temp_ext < lim_ext;
            assign lim.clear[i] = temp_ext >= (lim_ext + hyst_ext);
        end else begin : g_over
            assign lim.trip[i] = temp_ext > lim_ext;
            assign lim.clear[i] = temp_ext < (lim_ext - hyst_ext);
        end
    end
endmodule

/* File: temp_bank_properties.sv */
// Port checker for the temperature register bank
`timescale 1ns/10ps
module temp_bank_properties (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_wr_valid,
    input wire logic i_rd_req,
    input wire logic i_result_valid,
    input wire logic [15:0] i_result,
    input wire logic o_rd_valid,
    input wire logic [7:0] o_config,
    input wire logic [15:0] o_high_limit,
    input wire logic [15:0] o_low_limit,
    input wire logic [15:0] o_critical_limit,
    input wire logic [7:0] o_status,
    input wire logic o_soft_reset
);
    logic [15:0] cmp;
    logic quiet;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    // Result as compared; flag bits masked in 13-bit mode
    assign cmp = {i_result[15:3], o_config[7] ? i_result[2:0] : 3'h0};
    assign quiet = i_result_valid && !i_wr_valid && !o_soft_reset;
    a_read_answer: assert property (i_rd_req && !i_wr_valid |=> o_rd_valid)
        else $error("read not answered");
    a_valid_cause: assert property (o_rd_valid |-> $past(i_rd_req) && !$past(i_wr_valid))
        else $error("read strobe without request");
    a_done_on_result: assert property (i_result_valid |=> !o_status[7])
        else $error("done flag not driven low");
    a_status_zeros: assert property (o_status[3:0] == 4'h0)
        else $error("status low bits not zero");
    a_config_cause: assert property ($changed(o_config) |-> $past(i_wr_valid))
        else $error("configuration changed without write");
    a_limit_cause: assert property ($changed(o_high_limit) |->
        $past(i_wr_valid) || $past(o_soft_reset))
        else $error("high limit changed without write");
    a_crit_set: assert property (quiet && $signed(cmp) > $signed(o_critical_limit)
        |=> o_status[6])
        else $error("critical flag not set");
    a_low_set: assert property (quiet && $signed(cmp) < $signed(o_low_limit)
        |=> o_status[4])
        else $error("low flag not set");
    a_high_set: assert property (quiet && $signed(cmp) > $signed(o_high_limit)
        |=> o_status[5])
        else $error("high flag not set");
    a_high_rise: assert property ($rose(o_status[5]) |-> $past(i_result_valid))
        else $error("high flag set without result");
    a_soft_pulse: assert property (o_soft_reset |-> $past(i_wr_valid) ##1 !o_soft_reset)
        else $error("soft reset pulse malformed");
    // Main scenarios reached
    c_result: cover property (i_result_valid ##1 !o_status[7]);
    c_read: cover property (i_rd_req ##1 o_rd_valid);
    c_soft: cover property (o_soft_reset);
endmodule

/* File: host_bus_model.sv */
// Host side of the register byte bus
`timescale 1ns/10ps
module host_bus_model (
    input wire logic i_clock,
    input wire logic i_rd_valid,
    input wire logic [7:0] i_rd_data,
    output logic o_wr_valid,
    output logic o_wr_first,
    output logic [7:0] o_wr_data,
    output logic o_rd_req
);
    // Idle bus
    initial begin
        o_wr_valid = 1'b0;
        o_wr_first = 1'b0;
        o_wr_data = 8'h00;
        o_rd_req = 1'b0;
    end
    // One byte write; pointer byte when first is set
    task automatic put(input logic first, input logic [7:0] data);
        @(negedge i_clock);
        o_wr_valid = 1'b1;
        o_wr_first = first;
        o_wr_data = data;
        @(negedge i_clock);
        o_wr_valid = 1'b0;
        o_wr_data = ~data; // No stale byte on a released bus
    endtask
    // One byte read; answer taken one cycle after the request
    task automatic get(output logic ok, output logic [7:0] data);
        @(negedge i_clock);
        o_rd_req = 1'b1;
        @(negedge i_clock);
        o_rd_req = 1'b0;
        ok = i_rd_valid;
        data = i_rd_data;
    endtask
endmodule

/* File: test_temp_sensor_register_bank.sv */
// Self-checking bench for the temperature register bank
`timescale 1ns/10ps
module test_temp_sensor_register_bank;
    localparam logic [7:0] ID = 8'h3C; // Arbitrary identification value
    typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic res_v = 1'b0;
    logic [15:0] res = 16'h0000;
    logic wv, wf, rq, rv, srst, ok;
    logic [7:0] wd, rdd, cfg, hyst, st, d;
    logic [15:0] hi, lo, cr;
    int bad_count = 0;
    int checks_done = 0;
    row_t rows[12] = '{'{8'h03, 8'h1D, 8'h1D}, '{8'h04, 8'h7F, 8'h7F}, '{8'h05, 8'h01, 8'h01},
        '{8'h06, 8'hF0, 8'hF0}, '{8'h07, 8'h08, 8'h08}, '{8'h08, 8'h55, 8'h55},
        '{8'h09, 8'hAA, 8'hAA}, '{8'h0A, 8'h0F, 8'h0F}, '{8'h00, 8'h33, 8'h00},
        '{8'h02, 8'hFF, 8'h80}, '{8'h0B, 8'hFF, ID}, '{8'h10, 8'h77, 8'h00}};
    logic [7:0] dflt[12] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h20, 8'h00, 8'h05, 8'h00,
        8'h49, 8'h80, 8'h05, ID};
    temp_sensor_register_bank #(.IDENT_VALUE(ID)) uut (.i_clock(clk), .i_sys_rst(rst),
        .i_wr_valid(wv), .i_wr_first(wf), .i_wr_data(wd), .i_rd_req(rq),
        .i_result_valid(res_v), .i_result(res), .o_rd_data(rdd), .o_rd_valid(rv),
        .o_config(cfg), .o_high_limit(hi), .o_low_limit(lo), .o_critical_limit(cr),
        .o_hysteresis(hyst), .o_status(st), .o_soft_reset(srst));
    host_bus_model host (.i_clock(clk), .i_rd_valid(rv), .i_rd_data(rdd), .o_wr_valid(wv),
        .o_wr_first(wf), .o_wr_data(wd), .o_rd_req(rq));
    always #5 clk = ~clk;
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        host.put(1'b1, a);
        host.put(1'b0, v);
    endtask
    // Pointer write then one read
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        host.put(1'b1, a);
        host.get(ok, d);
        chk("rd_valid", ok, 1'b1);
        chk("rd_data", d, e);
    endtask
    task automatic conv(input logic [15:0] v);
        @(negedge clk);
        res_v = 1'b1;
        res = v;
        @(negedge clk);
        res_v = 1'b0;
        res = ~v;
    endtask
    task automatic defaults();
        for (int i = 0; i < 12; i++) rd(i[7:0], dflt[i]);
    endtask
    task automatic finish_test();
        if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        host.get(ok, d);
        chk("first_read", d, 8'h00);
        defaults();
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].e);
        end
        chk("high_limit", hi, 16'h7F01);
        chk("low_limit", lo, 16'hF008);
        chk("crit_limit", cr, 16'h55AA);
        chk("hysteresis", hyst, 8'h0F);
        wr(8'h2F, 8'h00);
        chk("soft_reset", srst, 1'b1);
        defaults();
        conv(16'h2100);
        chk("status", st, 8'h20);
        rd(8'h00, 8'h21);
        host.get(ok, d);
        chk("low_byte", d, 8'h02);
        chk("status", st, 8'hA0);
        rd(8'h02, 8'hA0);
        chk("status", st, 8'h80);
        conv(16'h2100);
        conv(16'h1B00);
        chk("status", st, 8'h00);
        conv(16'h4A00);
        chk("status", st, 8'h60);
        rd(8'h01, 8'h06);
        conv(16'h0100);
        chk("status", st, 8'h10);
        rd(8'h01, 8'h01);
        wr(8'h03, 8'h80);
        conv(16'hFFFF);
        rd(8'h00, 8'hFF);
        rd(8'h01, 8'hFF);
        for (int m = 0; m < 3; m++) begin
            conv(16'h0100);
            wr(8'h03, {1'b0, m[1:0], 5'h00});
            chk("done_mode", st[7], m != 0);
        end
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        chk("status", st, 8'h80);
        chk("config", cfg, 8'h00);
        chk("high_limit", hi, 16'h2000);
        chk("low_limit", lo, 16'h0500);
        chk("crit_limit", cr, 16'h4980);
        chk("hysteresis", hyst, 8'h05);
        finish_test();
    end
    // Watchdog
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        finish_test();
    end
endmodule
bind temp_sensor_register_bank temp_bank_properties props (.*);
